// *** design/rtc_function_control.v ***
// function control of the real-time clock: resolution, periodic timer,
// counting mode, halt source and the square-wave clock output.
// assumes a serial-bus front end that presents byte writes and reads
// as one-cycle strobes with an address; pin inputs are asynchronous.
//
// Operation
// - bit 7 selects 1 s or 0.01 s resolution
// - hundredths tick: 14 periods /3, 11 periods /2
// - bits 6:5 pick none, second, minute, hour
// - periodic timers held reset while select is 00
// - first event within period, not before period-1s; the count is kept, not cleared, when select changes between nonzero codes
// - periodic timers ignore the time-counting halt
// - every periodic event sets the periodic flag
// - periodic pulses continue while flag stays set
// - periodic length unaffected by offset calibration
// - bit 4 picks calendar or stop-watch counting
// - stop-watch hours span 0 to 999999
// - bit 3 lets stamp pin also halt counting
// - halt bit stops counting in both modes
// - pin halts at its active level unless bit halts
// - bits 2:0 pick output clock or static off
// - clock pin push-pull, low when disabled
// - selected clock also feeds stamp and irq-a pins
// - invert applies to all settings except 111
// - divided clocks have equal high and low times
// - stamp pin drives clock on main, floats on battery
// - irq-a open-drain clock on main only
// - periodic flag bit 7, write 0 clears, 1 keeps
`default_nettype none
`include "rtc_func_defs.vh"

module rtc_function_control (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        ce,
    // register port from the serial-bus front end
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // controls held in neighbouring registers
    input  wire        halt_bit,
    input  wire        clock_pin_disable,
    input  wire        clock_out_invert,
    input  wire        stamp_pin_polarity,
    input  wire [1:0]  stamp_pin_function,
    input  wire [1:0]  irq_a_pin_function,
    input  wire        on_battery,
    // asynchronous pins
    input  wire        osc_pin,
    input  wire        stamp_pin_in,
    // to the time counters and interrupt logic
    output reg         hundredths_enable,
    output reg         count_mode_select,
    output reg  [19:0] hours_limit,
    output reg         time_tick,
    output reg         count_halted,
    output reg         periodic_pulse,
    output reg         periodic_flag,
    // output pins
    output reg         clk_pin_out,
    output reg         stamp_pin_out,
    output reg         stamp_pin_oe,
    output reg         irq_a_pin_out,
    output reg         irq_a_pin_oe
);

    function [11:0] period_of;
        input [1:0] sel;
        begin
            case (sel)
                `PI_SECOND: period_of = `PERIOD_SECOND;
                `PI_MINUTE: period_of = `PERIOD_MINUTE;
                `PI_HOUR:   period_of = `PERIOD_HOUR;
                default:    period_of = 12'h000;
            endcase
        end
    endfunction

    function [`PRESCALE_WIDTH-1:0] prescale_step;
        input [`PRESCALE_WIDTH-1:0] value;
        begin
            prescale_step = value + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    // function_control fields
    reg  [1:0]  periodic_irq_select;
    reg         halt_source_select;
    reg  [2:0]  clkout_freq_select;
    reg         hund_field;
    reg         mode_field;

    // pin synchronisers
    reg         osc_meta;
    reg         osc_sync;
    reg         osc_last;
    reg         stamp_meta;
    reg         stamp_sync;

    reg  [`PRESCALE_WIDTH-1:0] prescale;
    reg  [11:0] periodic_count;

    wire        osc_rise;
    wire        tick256;
    wire        tick1hz;
    wire        hund_tick;
    wire        pin_active;
    wire        halted;
    wire [11:0] period;
    wire        periodic_event;
    wire        func_wr;
    wire        flags_wr;

    reg         next_clock;
    reg  [7:0]  next_rdata;

    assign osc_rise = osc_sync & ~osc_last;
    // prescaler runs straight from the oscillator, never from the calibrated
    // chain, so correction pulses cannot stretch a periodic interval
    assign tick256  = osc_rise & (prescale[6:0] == `TICK256_MASK);
    assign tick1hz  = osc_rise & (prescale == `TICK1HZ_MASK);

    assign func_wr  = reg_wr & (reg_addr == `FUNC_CTRL_ADDR);
    assign flags_wr = reg_wr & (reg_addr == `FLAGS_ADDR);

    // the pin polarity decides which level halts; function code is software's job
    assign pin_active = stamp_sync ^ stamp_pin_polarity;
    assign halted     = halt_bit | (halt_source_select & pin_active);

    assign period = period_of(periodic_irq_select);
    assign periodic_event = tick1hz & (periodic_irq_select != `PI_OFF) &
                            (periodic_count == period - 12'h001);

    hund_divider u_hund_divider (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (ce),
        .clear   (~hund_field | halted),
        .tick256 (tick256),
        .tick100 (hund_tick)
    );

    // synchronisers: the first stage feeds only the second
    always @(posedge clock) begin
        if (!rst_n) begin
            osc_meta   <= 1'b0;
            osc_sync   <= 1'b0;
            osc_last   <= 1'b0;
            stamp_meta <= 1'b0;
            stamp_sync <= 1'b0;
        end else if (ce) begin
            osc_meta   <= osc_pin;
            osc_sync   <= osc_meta;
            osc_last   <= osc_sync;
            stamp_meta <= stamp_pin_in;
            stamp_sync <= stamp_meta;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            prescale <= {`PRESCALE_WIDTH{1'b0}};
        end else if (ce && osc_rise) begin
            prescale <= prescale_step(prescale);
        end
    end

    // function register
    always @(posedge clock) begin
        if (!rst_n) begin
            hund_field          <= 1'b0;
            periodic_irq_select <= `PI_OFF;
            mode_field          <= 1'b0;
            halt_source_select  <= 1'b0;
            clkout_freq_select  <= `COF_32768;
        end else if (ce && func_wr) begin
            hund_field          <= reg_wdata[`FC_HUND_BIT];
            periodic_irq_select <= reg_wdata[`FC_PI_HI:`FC_PI_LO];
            mode_field          <= reg_wdata[`FC_MODE_BIT];
            halt_source_select  <= reg_wdata[`FC_HALT_SRC_BIT];
            clkout_freq_select  <= reg_wdata[`FC_COF_HI:`FC_COF_LO];
        end
    end

    // periodic timer: counts seconds regardless of the halt
    always @(posedge clock) begin
        if (!rst_n) begin
            periodic_count <= 12'h000;
        end else if (ce) begin
            if (periodic_irq_select == `PI_OFF) begin
                periodic_count <= 12'h000;
            end else if (tick1hz) begin
                if (periodic_event) begin
                    periodic_count <= 12'h000;
                end else begin
                    periodic_count <= periodic_count + 12'h001;
                end
            end
        end
    end

    // periodic pulse and flag; a new event beats a clear in the same cycle
    always @(posedge clock) begin
        if (!rst_n) begin
            periodic_pulse <= 1'b0;
            periodic_flag  <= 1'b0;
        end else if (ce) begin
            periodic_pulse <= periodic_event;
            if (periodic_event) begin
                periodic_flag <= 1'b1;
            end else if (flags_wr && !reg_wdata[`FLAG_PERIODIC_BIT]) begin
                periodic_flag <= 1'b0;
            end
        end
    end

    // time counting tick and mode outputs
    always @(posedge clock) begin
        if (!rst_n) begin
            time_tick         <= 1'b0;
            count_halted      <= 1'b0;
            hundredths_enable <= 1'b0;
            count_mode_select <= 1'b0;
            hours_limit       <= `HOURS_MAX_CLOCK;
        end else if (ce) begin
            count_halted      <= halted;
            hundredths_enable <= hund_field;
            count_mode_select <= mode_field;
            // stop-watch drops the calendar and lets hours run to the limit
            hours_limit       <= mode_field ? `HOURS_MAX_WATCH : `HOURS_MAX_CLOCK;
            if (halted) begin
                time_tick <= 1'b0;
            end else if (hund_field) begin
                time_tick <= hund_tick;
            end else begin
                time_tick <= tick1hz;
            end
        end
    end

    // output clock select; divided taps toggle on every nth edge so they are 50:50
    always @* begin
        case (clkout_freq_select)
            `COF_32768: next_clock = osc_sync;
            `COF_16384: next_clock = prescale[0];
            `COF_8192:  next_clock = prescale[1];
            `COF_4096:  next_clock = prescale[2];
            `COF_2048:  next_clock = prescale[3];
            `COF_1024:  next_clock = prescale[4];
            `COF_1HZ:   next_clock = prescale[14];
            default:    next_clock = 1'b0;
        endcase
        if (clkout_freq_select != `COF_OFF) begin
            next_clock = next_clock ^ clock_out_invert;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            clk_pin_out   <= 1'b0;
            stamp_pin_out <= 1'b0;
            stamp_pin_oe  <= 1'b0;
            irq_a_pin_out <= 1'b0;
            irq_a_pin_oe  <= 1'b0;
        end else if (ce) begin
            clk_pin_out   <= clock_pin_disable ? 1'b0 : next_clock;
            stamp_pin_out <= next_clock;
            stamp_pin_oe  <= (stamp_pin_function == `STAMP_FN_CLOCK) & ~on_battery;
            irq_a_pin_out <= 1'b0;
            // open drain: pull low while the clock is low, float otherwise
            irq_a_pin_oe  <= (irq_a_pin_function == `IRQA_FN_CLOCK) & ~on_battery &
                             (clkout_freq_select != `COF_OFF) & ~next_clock;
        end
    end

    // register read data
    always @* begin
        case (reg_addr)
            `FUNC_CTRL_ADDR: next_rdata = {hund_field, periodic_irq_select, mode_field,
                                           halt_source_select, clkout_freq_select};
            `FLAGS_ADDR:     next_rdata = {periodic_flag, 7'h00};
            default:         next_rdata = 8'h00;
        endcase
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // rtc_function_control

`default_nettype wire

// *** design/rtc_func_defs.vh ***
// constants for the function control block of the real-time clock
// assumes a 40 MHz system clock and a 32.768 kHz oscillator pin
`ifndef RTC_FUNC_DEFS_VH
`define RTC_FUNC_DEFS_VH

// register offsets on the serial register port
`define FUNC_CTRL_ADDR      8'h28
`define FLAGS_ADDR          8'h2b

// function_control field positions
`define FC_HUND_BIT         7
`define FC_PI_HI            6
`define FC_PI_LO            5
`define FC_MODE_BIT         4
`define FC_HALT_SRC_BIT     3
`define FC_COF_HI           2
`define FC_COF_LO           0
`define FUNC_CTRL_RESET     8'h00

// flags register
`define FLAG_PERIODIC_BIT   7

// periodic interrupt select codes
`define PI_OFF              2'h0
`define PI_SECOND           2'h1
`define PI_MINUTE           2'h2
`define PI_HOUR             2'h3

// periodic periods, in one-second ticks
`define PERIOD_SECOND       12'h001
`define PERIOD_MINUTE       12'h03c
`define PERIOD_HOUR         12'he10

// output clock select codes
`define COF_32768           3'h0
`define COF_16384           3'h1
`define COF_8192            3'h2
`define COF_4096            3'h3
`define COF_2048            3'h4
`define COF_1024            3'h5
`define COF_1HZ             3'h6
`define COF_OFF             3'h7

// stamp pin and irq-a pin function codes
`define STAMP_FN_CLOCK      2'h2
`define STAMP_FN_INPUT      2'h3
`define IRQA_FN_CLOCK       2'h0

// oscillator prescaler
`define PRESCALE_WIDTH      15
`define TICK256_MASK        7'h7f
`define TICK1HZ_MASK        15'h7fff

// hundredths divider pattern
`define HUND_LONG_PERIODS   5'h0e
`define HUND_PATTERN_LEN    5'h19
`define HUND_LONG_DIV       2'h3
`define HUND_SHORT_DIV      2'h2

// hours limit of each counting mode
`define HOURS_MAX_CLOCK     20'h0_0017
`define HOURS_MAX_WATCH     20'hf_423f

`endif

// *** design/hund_divider.v ***
// hundredths tick generator: 256 Hz ticks divided by 2.56 on average
// assumes tick256 is a one-cycle pulse on the same clock
`default_nettype none
`include "rtc_func_defs.vh"

module hund_divider (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       clear,
    input  wire       tick256,
    output reg        tick100
);

    reg  [4:0] phase;
    reg  [1:0] sub;
    wire [1:0] divisor;

    // fourteen periods of three, then eleven of two: no drift every 25 periods
    assign divisor = (phase < `HUND_LONG_PERIODS) ? `HUND_LONG_DIV : `HUND_SHORT_DIV;

    always @(posedge clock) begin
        if (!rst_n) begin
            phase   <= 5'h00;
            sub     <= 2'h0;
            tick100 <= 1'b0;
        end else if (ce) begin
            tick100 <= 1'b0;
            if (clear) begin
                phase <= 5'h00;
                sub   <= 2'h0;
            end else if (tick256) begin
                if (sub == divisor - 2'h1) begin
                    sub     <= 2'h0;
                    tick100 <= 1'b1;
                    if (phase == `HUND_PATTERN_LEN - 5'h01) begin
                        phase <= 5'h00;
                    end else begin
                        phase <= phase + 5'h01;
                    end
                end else begin
                    sub <= sub + 2'h1;
                end
            end
        end
    end

endmodule // hund_divider

`default_nettype wire

// *** bench/rtc_function_control_properties.sv ***
// port assertions for the function control block
// assumes the design header is on the include path; bound to every instance
`default_nettype none
`include "rtc_func_defs.vh"
module rtc_function_control_checker (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       halt_bit,
    input wire logic       clock_pin_disable,
    input wire logic       on_battery,
    input wire logic       time_tick,
    input wire logic       count_halted,
    input wire logic       periodic_pulse,
    input wire logic       periodic_flag,
    input wire logic       clk_pin_out,
    input wire logic       stamp_pin_oe,
    input wire logic       irq_a_pin_out,
    input wire logic       irq_a_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire flag_wr = ce && reg_wr && (reg_addr == `FLAGS_ADDR);

    chk_irqa_open_drain: assert property (irq_a_pin_out == 1'b0)
        else $error("irq-a pin data driven high");
    chk_irqa_battery_float: assert property (on_battery && $past(on_battery) |-> !irq_a_pin_oe)
        else $error("irq-a pin driven on battery");
    chk_stamp_battery_float: assert property (on_battery && $past(on_battery) |-> !stamp_pin_oe)
        else $error("stamp pin driven on battery");
    chk_clk_disabled_low: assert property (clock_pin_disable && $past(clock_pin_disable) |-> !clk_pin_out)
        else $error("clock pin not low while disabled");
    chk_event_sets_flag: assert property (periodic_pulse |-> periodic_flag)
        else $error("periodic event without flag");
    chk_pulse_one_cycle: assert property (periodic_pulse |=> !periodic_pulse)
        else $error("periodic pulse longer than one cycle");
    chk_flag_write_keeps: assert property (flag_wr && reg_wdata[7] && periodic_flag |=> periodic_flag)
        else $error("writing one changed the periodic flag");
    chk_flag_write_clears: assert property (flag_wr && !reg_wdata[7] |=> !periodic_flag || periodic_pulse)
        else $error("writing zero left the periodic flag set");
    chk_halt_bit_halts: assert property (halt_bit && $past(halt_bit) |-> count_halted)
        else $error("halt bit did not halt counting");
    chk_halted_no_tick: assert property (count_halted && $past(count_halted) |-> !time_tick)
        else $error("time step while halted");
endmodule // rtc_function_control_checker

bind rtc_function_control rtc_function_control_checker i_checker (
    .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .halt_bit(halt_bit), .clock_pin_disable(clock_pin_disable), .on_battery(on_battery),
    .time_tick(time_tick), .count_halted(count_halted), .periodic_pulse(periodic_pulse),
    .periodic_flag(periodic_flag), .clk_pin_out(clk_pin_out), .stamp_pin_oe(stamp_pin_oe),
    .irq_a_pin_out(irq_a_pin_out), .irq_a_pin_oe(irq_a_pin_oe));
`default_nettype wire

// *** bench/host_model.sv ***
// host side of the register port: byte writes, byte reads, stamp pin setup
// assumes requests launch on the falling edge and are taken on the next rising edge
`default_nettype none
module host_model (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic       stamp_pin_polarity,
    output var  logic [1:0] stamp_pin_function
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        stamp_pin_polarity = 1'b0;
        stamp_pin_function = 2'h2;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // pin halting is only meaningful once the pin is an input with a chosen polarity
    task automatic set_stamp_input(input logic pol);
        @(negedge clock);
        stamp_pin_function = 2'h3;
        stamp_pin_polarity = pol;
    endtask
endmodule // host_model
`default_nettype wire

// *** bench/tb_rtc_function_control.sv ***
// self-checking bench for the function control block
// assumes the oscillator runs at half the system clock, so one second is 65536 cycles
`default_nettype none
`include "rtc_func_defs.vh"
module tb_rtc_function_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        halt_bit = 1'b0;
    logic        clock_pin_disable = 1'b0;
    logic        clock_out_invert = 1'b0;
    logic        on_battery = 1'b0;
    logic        osc_pin = 1'b0;
    logic        stamp_pin_in = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
    logic        reg_wr, reg_rd, stamp_pin_polarity, hundredths_enable, count_mode_select, time_tick;
    logic [1:0]  stamp_pin_function;
    logic        count_halted, periodic_pulse, periodic_flag, clk_pin_out, stamp_pin_out;
    logic        stamp_pin_oe, irq_a_pin_out, irq_a_pin_oe;
    logic [19:0] hours_limit;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          hi[3];
    int          tg[3];

    host_model i_host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .stamp_pin_polarity(stamp_pin_polarity),
        .stamp_pin_function(stamp_pin_function));
    rtc_function_control i_dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .halt_bit(halt_bit), .clock_pin_disable(clock_pin_disable), .clock_out_invert(clock_out_invert),
        .stamp_pin_polarity(stamp_pin_polarity), .stamp_pin_function(stamp_pin_function),
        .irq_a_pin_function(2'h0), .on_battery(on_battery), .osc_pin(osc_pin), .stamp_pin_in(stamp_pin_in),
        .hundredths_enable(hundredths_enable), .count_mode_select(count_mode_select),
        .hours_limit(hours_limit), .time_tick(time_tick), .count_halted(count_halted),
        .periodic_pulse(periodic_pulse), .periodic_flag(periodic_flag), .clk_pin_out(clk_pin_out),
        .stamp_pin_out(stamp_pin_out), .stamp_pin_oe(stamp_pin_oe), .irq_a_pin_out(irq_a_pin_out),
        .irq_a_pin_oe(irq_a_pin_oe));

    always #12.5 clock = ~clock;
    // scaled oscillator keeps a full second of prescaling inside the cycle budget
    always @(negedge clock) osc_pin <= ~osc_pin;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask
    // highs and toggles of clock pin, stamp pin and irq-a drive over 128 cycles
    task automatic measure();
        logic [2:0] cur;
        logic [2:0] prev;
        hi = '{0, 0, 0};
        tg = '{0, 0, 0};
        repeat (2) @(negedge clock);
        prev = {irq_a_pin_oe, stamp_pin_out, clk_pin_out};
        for (int i = 0; i < 128; i++) begin
            @(negedge clock);
            cur = {irq_a_pin_oe, stamp_pin_out, clk_pin_out};
            for (int j = 0; j < 3; j++) begin
                hi[j] += cur[j];
                tg[j] += cur[j] ^ prev[j];
            end
            prev = cur;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        int k;
        int t;
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        i_host.read_reg(`FUNC_CTRL_ADDR, rd);
        check(rd, 8'h00);
        check({hours_limit, hundredths_enable, count_mode_select}, {20'h0_0017, 2'h0});
        i_host.write_reg(`FUNC_CTRL_ADDR, 8'h90);
        i_host.read_reg(`FUNC_CTRL_ADDR, rd);
        check(rd, 8'h90);
        check({hundredths_enable, count_mode_select}, 2'h3);
        check(hours_limit, 20'hf_423f);
        i_host.read_reg(8'h40, rd);
        check(rd, 8'h00);
        for (k = 0; k < 4; k++) begin
            i_host.write_reg(`FUNC_CTRL_ADDR, 8'(k << 5));
            i_host.read_reg(`FUNC_CTRL_ADDR, rd);
            check(rd, 8'(k << 5));
        end
        for (k = 1; k < 6; k++) begin
            i_host.write_reg(`FUNC_CTRL_ADDR, 8'(k));
            measure();
            check(hi[0], 64);
            check(tg[0], 128 >> k);
            check(tg[1], 128 >> k);
            check(tg[2], 128 >> k);
        end
        clock_out_invert = 1'b1;
        i_host.write_reg(`FUNC_CTRL_ADDR, 8'h07);
        measure();
        check(hi[0] + hi[1] + hi[2] + tg[0], 0);
        clock_out_invert = 1'b0;
        clock_pin_disable = 1'b1;
        i_host.write_reg(`FUNC_CTRL_ADDR, 8'h00);
        measure();
        check(hi[0], 0);
        check({stamp_pin_oe, 32'(tg[1])}, {1'b1, 32'd128});
        on_battery = 1'b1;
        measure();
        check({stamp_pin_oe, 32'(tg[2] + hi[2])}, 33'd0);
        on_battery = 1'b0;
        clock_pin_disable = 1'b0;
        i_host.write_reg(`FUNC_CTRL_ADDR, 8'h08);
        i_host.set_stamp_input(1'b0);
        stamp_pin_in = 1'b1;
        repeat (6) @(negedge clock);
        check(count_halted, 1'b1);
        i_host.set_stamp_input(1'b1);
        repeat (6) @(negedge clock);
        check(count_halted, 1'b0);
        stamp_pin_in = 1'b0;
        repeat (6) @(negedge clock);
        check(count_halted, 1'b1);
        i_host.write_reg(`FUNC_CTRL_ADDR, 8'h80);
        repeat (6) @(negedge clock);
        check(count_halted, 1'b0);
        t = 0;
        repeat (16384) begin
            @(negedge clock);
            t += time_tick;
        end
        check(t, 25);
        halt_bit = 1'b1;
        check(periodic_flag, 1'b0);
        i_host.write_reg(`FUNC_CTRL_ADDR, 8'ha0);
        t = 0;
        for (k = 0; k < 66000 && periodic_pulse !== 1'b1; k++) begin
            @(negedge clock);
            t += time_tick;
        end
        check({periodic_pulse, periodic_flag}, 2'h3);
        check(t, 0);
        i_host.read_reg(`FLAGS_ADDR, rd);
        check(rd[7], 1'b1);
        i_host.write_reg(`FLAGS_ADDR, 8'h80);
        check(periodic_flag, 1'b1);
        i_host.write_reg(`FLAGS_ADDR, 8'h00);
        @(negedge clock);
        check(periodic_flag, 1'b0);
        report_and_stop();
    end
endmodule // tb_rtc_function_control
`default_nettype wire
